/* design/pdr_defines.svh */
// constants for the page decode and ready steering block
// assumes a 20-bit processor address and a 32-bit apb register bus
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - every address inside either selected 128k page is taken as an on-board access.
// - the ram page and the prom page are each chosen from the same four candidate pages.
// - out of reset ram sits at 00000-1ffff and prom at e0000-fffff.
// - ram and prom always use two different pages; a setting that makes them equal is refused.
// - in delayed mode a fail-safe timeout before the grant holds ready back until the bus is won.
// - in immediate mode a fail-safe timeout before the grant raises ready at once.
// - in immediate mode ready one is the bus acknowledge anded with the address-driver enable.
// - in delayed mode ready one is the bus acknowledge alone.
// - the bus address drivers are enabled only while the board owns the bus.
// - each of the two expansion sockets has its own 8/16-bit width option.
// - the clock-rate option selects 8 mhz when set and 5 mhz when clear.
`ifndef PDR_DEFINES_SVH
`define PDR_DEFINES_SVH

// ------------------------------------------------------------------
// address map of the block's own registers
// ------------------------------------------------------------------
`define PDR_CFG_OFFSET      12'h000
`define PDR_STATUS_OFFSET   12'h004

// ------------------------------------------------------------------
// configuration fields
// ------------------------------------------------------------------
`define PDR_CFG_RAM_LSB     0
`define PDR_CFG_PROM_LSB    2
`define PDR_CFG_IMMED_BIT   4
`define PDR_CFG_WIDE_LSB    5
`define PDR_CFG_FAST_BIT    7
`define PDR_CFG_RESET       32'h0000_008C

// ------------------------------------------------------------------
// page geometry: a page is 128k, address bits 19:17
// ------------------------------------------------------------------
`define PDR_PAGE_LSB        17
`define PDR_CAND_PAGE0      3'h0
`define PDR_CAND_PAGE1      3'h1
`define PDR_CAND_PAGE2      3'h6
`define PDR_CAND_PAGE3      3'h7

`endif

/* design/pdr_pkg.sv */
// types shared by the page decode and ready steering block
// assumes pdr_defines.svh for all numeric constants
package pdr_pkg;

   // ------------------------------------------------------------------
   // access sequencer states, gray along idle-req-own-done
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PDR_IDLE = 2'h0,
      PDR_REQ  = 2'h1,
      PDR_OWN  = 2'h3,
      PDR_DONE = 2'h2
   } pdr_state_type;

endpackage

/* design/pdr_decode.sv */
// on-board page decoder, purely combinational
// assumes static page selects that never name the same page twice
`timescale 1ns/1ns
`include "pdr_defines.svh"
module pdr_decode
   import pdr_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [1:0]        ram_sel_i,
   input  wire logic [1:0]        prom_sel_i,
   output logic                   ram_hit_o,
   output logic                   prom_hit_o
);

   // ------------------------------------------------------------------
   // candidate page lookup
   // ------------------------------------------------------------------
   function automatic logic [2:0] cand_page(input logic [1:0] sel);
      case (sel)
         2'h0:    cand_page = `PDR_CAND_PAGE0;
         2'h1:    cand_page = `PDR_CAND_PAGE1;
         2'h2:    cand_page = `PDR_CAND_PAGE2;
         default: cand_page = `PDR_CAND_PAGE3;
      endcase
   endfunction

   logic [2:0] page;

   always_comb begin
      page       = addr_i[ADDR_W-1:`PDR_PAGE_LSB];
      ram_hit_o  = (page == cand_page(ram_sel_i));
      prom_hit_o = (page == cand_page(prom_sel_i));
   end

endmodule // pdr_decode

/* design/pdr_ready.sv */
// ready steering toward the clock generator, combinational
// assumes synchronised acknowledge, grant and timeout levels
`timescale 1ns/1ns
module pdr_ready
   import pdr_pkg::*;
(
   input  wire logic immed_i,
   input  wire logic ack_i,
   input  wire logic aen_i,
   input  wire logic timeout_i,
   input  wire logic owned_i,
   output logic      ready1_o,
   output logic      release_o
);

   always_comb begin
      ready1_o  = immed_i ? (ack_i & aen_i) : ack_i;
      // delayed mode lets a timeout through only once the bus is owned
      release_o = ready1_o | (timeout_i & (immed_i | owned_i));
   end

endmodule // pdr_ready

/* design/pdr_top.sv */
// page decode, bus request and ready steering with apb configuration
// assumes cpu requests on clk_i; bus pins arrive from another domain
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "pdr_defines.svh"
module pdr_top
   import pdr_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic                   pready_o,
   output logic                   pslverr_o,
   output logic [31:0]            prdata_o,
   // processor side
   input  wire logic              cpu_req_i,
   input  wire logic [ADDR_W-1:0] cpu_addr_i,
   output logic                   cpu_ready_o,
   output logic                   ram_sel_o,
   output logic                   prom_sel_o,
   // system bus side
   input  wire logic              bus_grant_i,
   input  wire logic              xfer_ack_n_i,
   input  wire logic              failsafe_timeout_i,
   output logic                   bus_req_o,
   output logic                   bus_addr_driver_enable_n_o,
   // static options
   output logic [1:0]             sock_wide_o,
   output logic                   clk_rate_fast_o
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic       grant_s;
   logic       ack_s;
   logic       tmo_s;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= 3'h1;
         sync_reg <= 3'h1;
      end else begin
         meta_reg <= {failsafe_timeout_i, bus_grant_i, xfer_ack_n_i};
         sync_reg <= meta_reg;
      end
   end

   assign ack_s   = ~sync_reg[0];
   assign grant_s = sync_reg[1];
   assign tmo_s   = sync_reg[2];

   // ------------------------------------------------------------------
   // apb register file
   // ------------------------------------------------------------------
   logic [31:0]   cfg_reg;
   logic [31:0]   cfg_next;
   logic          pready_reg;
   logic          pready_next;
   logic          pslverr_reg;
   logic          pslverr_next;
   logic [31:0]   prdata_reg;
   logic [31:0]   prdata_next;
   logic [31:0]   status_word;
   logic          cfg_ok;
   logic          do_acc;
   pdr_state_type state_reg;
   pdr_state_type state_next;
   logic          ram_hit;
   logic          prom_hit;

   assign do_acc = psel_i & penable_i & pready_reg;
   // equal pages would alias ram and prom onto one page
   assign cfg_ok = pwdata_i[`PDR_CFG_RAM_LSB +: 2] != pwdata_i[`PDR_CFG_PROM_LSB +: 2];

   always_comb begin
      status_word    = 32'h0000_0000;
      status_word[1:0] = state_reg;
      status_word[2] = grant_s;
      status_word[3] = ack_s;
      status_word[4] = tmo_s;
      status_word[5] = ram_hit;
      status_word[6] = prom_hit;
      cfg_next     = cfg_reg;
      pready_next  = psel_i & penable_i & ~pready_reg;
      pslverr_next = 1'b0;
      prdata_next  = 32'h0000_0000;
      if (psel_i & penable_i & ~pready_reg) begin
         case (paddr_i)
            `PDR_CFG_OFFSET: begin
               prdata_next  = cfg_reg;
               pslverr_next = pwrite_i & ~cfg_ok;
            end
            `PDR_STATUS_OFFSET: begin
               prdata_next  = status_word;
               pslverr_next = pwrite_i;
            end
            default: begin
               pslverr_next = 1'b1;
            end
         endcase
      end
      if (do_acc & pwrite_i & ~pslverr_reg & (paddr_i == `PDR_CFG_OFFSET)) begin
         cfg_next = {24'h00_0000, pwdata_i[7:0]};
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_reg     <= `PDR_CFG_RESET;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         cfg_reg     <= cfg_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   assign pready_o        = pready_reg;
   assign pslverr_o       = pslverr_reg;
   assign prdata_o        = prdata_reg;
   assign sock_wide_o     = cfg_reg[`PDR_CFG_WIDE_LSB +: 2];
   assign clk_rate_fast_o = cfg_reg[`PDR_CFG_FAST_BIT];

   // ------------------------------------------------------------------
   // decode and ready steering
   // ------------------------------------------------------------------
   logic immed;
   logic ready1;
   logic rel;
   logic owned;

   assign immed = cfg_reg[`PDR_CFG_IMMED_BIT];
   assign owned = (state_reg == PDR_OWN);

   pdr_decode #(
      .ADDR_W     (ADDR_W)
   ) u_decode (
      .addr_i     (cpu_addr_i),
      .ram_sel_i  (cfg_reg[`PDR_CFG_RAM_LSB +: 2]),
      .prom_sel_i (cfg_reg[`PDR_CFG_PROM_LSB +: 2]),
      .ram_hit_o  (ram_hit),
      .prom_hit_o (prom_hit)
   );

   // acknowledge enters ungated; only immediate mode adds the owned term
   pdr_ready u_ready (
      .immed_i    (immed),
      .ack_i      (ack_s),
      .aen_i      (owned),
      .timeout_i  (tmo_s),
      .owned_i    (owned),
      .ready1_o   (ready1),
      .release_o  (rel)
   );

   // ------------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------------
   logic ready_reg;
   logic ready_next;
   logic req_reg;
   logic req_next;
   logic aen_n_reg;
   logic aen_n_next;
   logic rsel_reg;
   logic rsel_next;
   logic psel_reg;
   logic psel_next;

   always_comb begin
      state_next = state_reg;
      rsel_next  = rsel_reg;
      psel_next  = psel_reg;
      case (state_reg)
         PDR_IDLE: begin
            if (cpu_req_i) begin
               rsel_next  = ram_hit;
               psel_next  = prom_hit;
               // off-board when neither page matches
               state_next = (ram_hit | prom_hit) ? PDR_DONE : PDR_REQ;
            end
         end
         PDR_REQ: begin
            if (rel) begin
               state_next = PDR_DONE;
            end else if (grant_s) begin
               state_next = PDR_OWN;
            end
         end
         PDR_OWN: begin
            if (rel) begin
               state_next = PDR_DONE;
            end
         end
         PDR_DONE: begin
            state_next = PDR_IDLE;
            rsel_next  = 1'b0;
            psel_next  = 1'b0;
         end
         default: begin
            state_next = PDR_IDLE;
         end
      endcase
      ready_next = (state_next == PDR_DONE);
      req_next   = (state_next == PDR_REQ) | (state_next == PDR_OWN);
      aen_n_next = ~(state_next == PDR_OWN);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= PDR_IDLE;
         ready_reg <= 1'b0;
         req_reg   <= 1'b0;
         aen_n_reg <= 1'b1;
         rsel_reg  <= 1'b0;
         psel_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= ready_next;
         req_reg   <= req_next;
         aen_n_reg <= aen_n_next;
         rsel_reg  <= rsel_next;
         psel_reg  <= psel_next;
      end
   end

   assign cpu_ready_o                = ready_reg;
   assign bus_req_o                  = req_reg;
   assign bus_addr_driver_enable_n_o = aen_n_reg;
   assign ram_sel_o                  = rsel_reg;
   assign prom_sel_o                 = psel_reg;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_cfg_distinct : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      cfg_reg[`PDR_CFG_RAM_LSB +: 2] != cfg_reg[`PDR_CFG_PROM_LSB +: 2])
      else $error("ram and prom share a page");

   a_default_map : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (cfg_reg[3:0] == 4'hC) |->
         (ram_hit == (cpu_addr_i[ADDR_W-1:17] == 3'h0)) &&
         (prom_hit == (cpu_addr_i[ADDR_W-1:17] == 3'h7)))
      else $error("default map wrong");

   a_local_ready : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_IDLE && cpu_req_i && (ram_hit || prom_hit))
         |=> cpu_ready_o && !bus_req_o ##1 !cpu_ready_o)
      else $error("local access not one cycle");

   a_offboard_req : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_IDLE && cpu_req_i && !ram_hit && !prom_hit)
         |=> bus_req_o && !cpu_ready_o)
      else $error("off-board access did not request bus");

   a_aen_owned : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      !bus_addr_driver_enable_n_o |-> bus_req_o && ($past(grant_s) || $past(owned)))
      else $error("drivers on without bus");

   a_delay_hold : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_REQ && tmo_s && !immed && !grant_s) |=> !cpu_ready_o)
      else $error("delayed mode released early");

   a_immed_go : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_REQ && tmo_s && immed) |=> cpu_ready_o ##1 !bus_req_o)
      else $error("immediate mode did not release");

   a_ack_gate : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_OWN && ack_s) |=> cpu_ready_o ##1 bus_addr_driver_enable_n_o)
      else $error("acknowledge did not end transfer");

   // ready one wiring per mode, checked at the steering output
   a_delayed_ack : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      !immed |-> (ready1 == ack_s))
      else $error("delayed ready one is gated");

   a_immed_ack : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      immed |-> (ready1 == (ack_s && owned)))
      else $error("immediate ready one lacks driver gate");

   a_delay_no_skip : assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == PDR_REQ && !immed && !ack_s) |=> (state_reg != PDR_DONE))
      else $error("delayed mode ended access before owning bus");

endmodule // pdr_top

/* verification/pdr_bus_model.sv */
// system bus model: arbiter grant, transfer acknowledge, fail-safe timer
// assumes the board's registered bus request and address-driver enable
`timescale 1ns/1ns
module pdr_bus_model (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       bus_req_i,
   input  wire logic       aen_n_i,
   input  wire logic [7:0] grant_dly_i,
   input  wire logic [7:0] ack_dly_i,
   input  wire logic [7:0] to_dly_i,
   output logic            bus_grant_o,
   output logic            xfer_ack_n_o,
   output logic            failsafe_timeout_o
);
   // ------------------------------------------------------------------
   // request and ownership counters; a delay of ff means never
   // ------------------------------------------------------------------
   logic [7:0] req_cnt_reg;
   logic [7:0] own_cnt_reg;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_cnt_reg <= 8'h00;
         own_cnt_reg <= 8'h00;
      end else begin
         req_cnt_reg <= bus_req_i ? req_cnt_reg + 8'(req_cnt_reg != 8'hFF) : 8'h00;
         own_cnt_reg <= (bus_req_i && !aen_n_i) ? own_cnt_reg + 8'h01 : 8'h00;
      end
   end

   // every line follows the request; ack is pulled up as soon as the drivers turn off
   assign bus_grant_o        = bus_req_i && grant_dly_i != 8'hFF && req_cnt_reg >= grant_dly_i;
   assign failsafe_timeout_o = bus_req_i && to_dly_i != 8'hFF && req_cnt_reg >= to_dly_i;
   assign xfer_ack_n_o       = !(bus_req_i && !aen_n_i && ack_dly_i != 8'hFF
                                 && own_cnt_reg != 8'h00 && own_cnt_reg >= ack_dly_i);
endmodule // pdr_bus_model

/* verification/tb_page_decode_ready_select.sv */
// self-checking bench: apb configuration, local decode, off-board ready paths
// assumes pdr_bus_model compiled first; 100 mhz clock
`timescale 1ns/1ns
`include "pdr_defines.svh"
module tb_page_decode_ready_select;
   import pdr_pkg::*;
   logic        clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, r;
   logic        pready_o, pslverr_o, cpu_req_i = 0, cpu_ready_o, ram_sel_o, prom_sel_o, e, aen;
   logic [19:0] cpu_addr_i = 0;
   logic        bus_grant_i, xfer_ack_n_i, failsafe_timeout_i, bus_req_o;
   logic        bus_addr_driver_enable_n_o, clk_rate_fast_o;
   logic [1:0]  sock_wide_o;
   logic [7:0]  g_dly = 8'hFF, a_dly = 8'hFF, t_dly = 8'hFF;
   logic [7:0]  opt [3] = '{8'h6C, 8'hAC, 8'hCC};
   logic [2:0]  pg [4] = '{`PDR_CAND_PAGE0, `PDR_CAND_PAGE1, `PDR_CAND_PAGE2, `PDR_CAND_PAGE3};
   int          err_total = 0, n_checks = 0, lat;

   always #5 clk_i = ~clk_i;

   pdr_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
      .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_ready_o(cpu_ready_o),
      .ram_sel_o(ram_sel_o), .prom_sel_o(prom_sel_o), .bus_grant_i(bus_grant_i),
      .xfer_ack_n_i(xfer_ack_n_i), .failsafe_timeout_i(failsafe_timeout_i),
      .bus_req_o(bus_req_o), .bus_addr_driver_enable_n_o(bus_addr_driver_enable_n_o),
      .sock_wide_o(sock_wide_o), .clk_rate_fast_o(clk_rate_fast_o));

   pdr_bus_model i_bus (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_o),
      .aen_n_i(bus_addr_driver_enable_n_o), .grant_dly_i(g_dly), .ack_dly_i(a_dly),
      .to_dly_i(t_dly), .bus_grant_o(bus_grant_i), .xfer_ack_n_o(xfer_ack_n_i),
      .failsafe_timeout_o(failsafe_timeout_i));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         $display("wrong value %s expected %h seen %h", nm, x, s);
         err_total++;
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // request held until the edge where pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // pready and its data change at a rising edge, are read at the falling edge and stand through the next rising edge
      do begin
         @(negedge clk_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      @(posedge clk_i);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // one cpu access; aen notes whether the board ever owned the bus
   task automatic cpu_go(input logic [19:0] a, input logic er, input logic ep);
      cpu_addr_i <= a;
      cpu_req_i  <= 1'b1;
      @(posedge clk_i);
      cpu_req_i <= 1'b0;
      lat = 0;
      aen = 1'b0;
      #1;
      while (cpu_ready_o !== 1'b1 && lat < 200) begin
         if (bus_addr_driver_enable_n_o === 1'b0)
            aen = 1'b1;
         @(posedge clk_i);
         #1;
         lat++;
      end
      chk("ram_sel", ram_sel_o, er);
      chk("prom_sel", prom_sel_o, ep);
      @(posedge clk_i);
      chk("aen_idle", bus_addr_driver_enable_n_o, 1'b1);
   endtask

   task automatic far(input logic [7:0] gd, input logic [7:0] ad, input logic [7:0] td);
      g_dly <= gd;
      a_dly <= ad;
      t_dly <= td;
      cpu_go(20'h4_0000, 1'b0, 1'b0);
      chk("far_done", lat < 200, 1'b1);
   endtask

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      chk("sock_wide", sock_wide_o, 2'b00);
      chk("clk_fast", clk_rate_fast_o, 1'b1);
      apb(1'b0, `PDR_CFG_OFFSET, 32'h0000_0000);
      chk("cfg_reset", r, `PDR_CFG_RESET);
      cpu_go(20'h0_0000, 1'b1, 1'b0);
      cpu_go(20'h1_FFFF, 1'b1, 1'b0);
      cpu_go(20'hE_0000, 1'b0, 1'b1);
      cpu_go(20'hF_FFFF, 1'b0, 1'b1);
      $display("test reset_map done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `PDR_CFG_OFFSET, 32'(i + 4 * (3 - i)));
         chk("cfg_err", e, 1'b0);
         cpu_go({pg[i], 17'h0_0000}, 1'b1, 1'b0);
         chk("local_lat", lat, 0);
         cpu_go({pg[i], 17'h1_FFFF}, 1'b1, 1'b0);
         cpu_go({pg[3 - i], 17'h0_0000}, 1'b0, 1'b1);
         cpu_go({pg[3 - i], 17'h1_FFFF}, 1'b0, 1'b1);
      end
      $display("test page_select done");
      apb(1'b1, `PDR_CFG_OFFSET, 32'h0000_0005);
      chk("same_page_err", e, 1'b1);
      apb(1'b0, `PDR_CFG_OFFSET, 32'h0000_0000);
      chk("cfg_kept", r, 32'h0000_0003);
      apb(1'b1, `PDR_STATUS_OFFSET, 32'h0000_0000);
      chk("status_wr_err", e, 1'b1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("unmapped_err", e, 1'b1);
      chk("unmapped_data", r, 32'h0000_0000);
      $display("test refusals done");
      foreach (opt[k]) begin
         apb(1'b1, `PDR_CFG_OFFSET, {24'h00_0000, opt[k]});
         chk("sock_wide", sock_wide_o, opt[k][6:5]);
         chk("clk_fast", clk_rate_fast_o, opt[k][7]);
      end
      $display("test options done");
      far(8'h03, 8'h02, 8'hFF);
      chk("owned", aen, 1'b1);
      far(8'h0C, 8'h02, 8'h02);
      chk("owned", aen, 1'b1);
      chk("held_off", lat > 12, 1'b1);
      apb(1'b1, `PDR_CFG_OFFSET, 32'h0000_00DC);
      far(8'h0C, 8'h02, 8'h02);
      chk("owned", aen, 1'b0);
      chk("prompt", lat < 12, 1'b1);
      far(8'h03, 8'h02, 8'hFF);
      chk("owned", aen, 1'b1);
      $display("test ready_paths done");
      stop_test();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
endmodule // tb_page_decode_ready_select
